// ==== bench/lrs_coil_model.sv ====
`timescale 1ns/1ps
// Two coil tanks with their threshold comparators
module lrs_coil_model #(
  parameter int OSC_N = 6, // Full swings per undamped ring-down
  parameter int HALF_NS = 510 // Half period, tone just under 1 MHz
) (
  input wire logic [1:0] kick_n, // Charge pulses, low active
  input wire logic [1:0] damp, // Metal in front of each coil
  output logic [1:0] sense // Comparator outputs, low when quiet
);
  // ==========================================================
  // Ring-down after the end of each charge pulse
  for (genvar i = 0; i < 2; i++) begin : g_coil
    initial begin
      sense[i] = 1'b0;
      forever begin
        @(negedge kick_n[i]);
        @(posedge kick_n[i]);
        // Dampened tank never passes the threshold; offset avoids edges
        if (!damp[i]) begin
          #3;
          repeat (OSC_N) begin
            #(HALF_NS) sense[i] = 1'b1;
            #(HALF_NS) sense[i] = 1'b0;
          end
        end
      end
    end
  end
endmodule

// ==== bench/lrs_seq_sva.sv ====
`timescale 1ns/1ps
// Port-level checks of kick timing and register bus answers
module lrs_seq_sva #(
  parameter int KICK_LEN = 10 // Kick length after reset
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low active
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic sample_tick, // Wake pulse
  input wire logic [1:0] osc_kick_line // Kick outputs
);
  logic [7:0] kick_low_cnt_r;

  // ==========================================================
  // Helper: length of the running kick, either line
  always_ff @(posedge aclk) begin
    if (!aresetn || &osc_kick_line) kick_low_cnt_r <= 8'h00;
    else kick_low_cnt_r <= kick_low_cnt_r + 8'h01;
  end

  // ==========================================================
  // Sequences of one measurement pair
  sequence s_kick0_end;
    $rose(osc_kick_line[0]);
  endsequence
  sequence s_kick1_start;
    ##[1:1000] $fell(osc_kick_line[1]);
  endsequence

  // ==========================================================
  // Assertions
  a_kick_reset_high: assert property (@(posedge aclk)
    !aresetn |=> osc_kick_line == 2'b11)
    else $error("kick line low after reset");
  a_kick_never_both: assert property (@(posedge aclk)
    disable iff (!aresetn) osc_kick_line != 2'b00)
    else $error("both coils kicked at once");
  a_kick_pulse_width: assert property (@(posedge aclk)
    disable iff (!aresetn) $rose(&osc_kick_line) |-> kick_low_cnt_r == KICK_LEN)
    else $error("kick pulse length wrong");
  a_tick_starts_kick: assert property (@(posedge aclk)
    disable iff (!aresetn) $fell(osc_kick_line[0]) |-> $past(sample_tick, 2))
    else $error("first kick without wake tick");
  a_second_follows_first: assert property (@(posedge aclk)
    disable iff (!aresetn) s_kick0_end |-> s_kick1_start)
    else $error("second coil not kicked after first");
  a_read_answer_next: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_release_next: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  a_write_release_next: assert property (@(posedge aclk)
    disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
    else $error("write channel not released");
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`include "lrs_map.svh"
bind lrs_sequencer lrs_seq_sva u_sva (.aclk, .aresetn, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .sample_tick, .osc_kick_line);
module testbench;
  logic aclk, aresetn, sample_tick;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, ef, eb;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ee;
  logic [1:0] s_axi_bresp, s_axi_rresp, osc_sense_line, osc_kick_line;
  logic [1:0] damp, rs, cur, prev;
  int fails, check_count;
  logic [1:0] pos_seq [9] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h3,
                              2'h1, 2'h2};

  lrs_sequencer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_tick,
    .osc_sense_line, .osc_kick_line);
  lrs_coil_model u_coils (.kick_n(osc_kick_line), .damp,
    .sense(osc_sense_line));

  // ==========================================================
  // Clock and watchdog, sized well above the sample sequence
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    end_sim();
  end

  // ==========================================================
  // Bus and compare tasks
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic check_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_resp(input string nm, input logic [1:0] e,
                            input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    axi_read(a, rd, rs);
    check_resp(nm, `LRS_RESP_OKAY, rs);
    check_word(nm, e, rd);
  endtask
  // Wake, a second wake that must be ignored, then wait for rest
  task automatic sample();
    @(posedge aclk);
    sample_tick <= 1'b1;
    @(posedge aclk);
    sample_tick <= 1'b0;
    repeat (4) @(posedge aclk);
    sample_tick <= 1'b1;
    @(posedge aclk);
    sample_tick <= 1'b0;
    do axi_read(`LRS_REG_STATUS, rd, rs); while (rd[`LRS_ST_BUSY] !== 1'b0);
    // Let the ring-down finish so no stray swing reaches the next run
    repeat (300) @(posedge aclk);
  endtask
  function automatic logic [1:0] fwd_of(input logic [1:0] p);
    case (p)
      2'h0: return 2'h1;
      2'h1: return 2'h3;
      2'h3: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction
  task automatic end_sim();
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, sample_tick} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    damp = 2'h1;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    do axi_read(`LRS_REG_STATUS, rd, rs); while (rd[`LRS_ST_READY] !== 1'b1);
    rd_chk("status", `LRS_REG_STATUS, 32'h40);
    rd_chk("kick", `LRS_REG_KICK, 32'd10);
    rd_chk("target", `LRS_REG_TARGET, 32'd22);
    rd_chk("timeout", `LRS_REG_TMO, 32'd1560);
    axi_write(`LRS_REG_FWD, 32'h5, rs);
    check_resp("ro_write", `LRS_RESP_OKAY, rs);
    rd_chk("fwd", `LRS_REG_FWD, 32'h0);
    rd_chk("bwd", `LRS_REG_BWD, 32'h0);
    axi_write(8'h40, 32'h1, rs);
    check_resp("bad_write", `LRS_RESP_SLVERR, rs);
    axi_read(8'h40, rd, rs);
    check_resp("bad_read", `LRS_RESP_SLVERR, rs);
    check_word("bad_data", 32'h0, rd);
    sample();
    rd_chk("disabled", `LRS_REG_STATUS, 32'h40);
    axi_write(`LRS_REG_TARGET, 32'd4, rs);
    axi_write(`LRS_REG_TMO, 32'd400, rs);
    axi_write(`LRS_REG_CTRL, 32'h1, rs);
    {ef, eb, ee, prev} = '0;
    foreach (pos_seq[i]) begin
      cur = pos_seq[i];
      damp <= {cur[0], cur[1]};
      if (cur == fwd_of(prev)) ef++;
      else if (prev == fwd_of(cur)) eb++;
      else if (cur != prev) ee = 1'b1;
      sample();
      rd_chk("status", `LRS_REG_STATUS, {25'h0, 2'b10, ee, cur, cur});
      rd_chk("fwd", `LRS_REG_FWD, ef);
      rd_chk("bwd", `LRS_REG_BWD, eb);
      rd_chk("net", `LRS_REG_NET, ef - eb);
      for (int j = 0; j < 2; j++) begin
        axi_read(`LRS_REG_CAP1 + 8'(4 * j), rd, rs);
        if (cur[1 - j]) check_word("cap_damp", 32'h2, rd);
        else check_word("cap_live", 32'h1, {31'h0, rd > 2 && rd < 400});
      end
      prev = cur;
    end
    axi_write(`LRS_REG_STATUS, 32'h10, rs);
    rd_chk("err_clear", `LRS_REG_STATUS, 32'h4a);
    axi_write(`LRS_REG_CTRL, 32'h3, rs);
    rd_chk("fwd_clr", `LRS_REG_FWD, 32'h0);
    rd_chk("bwd_clr", `LRS_REG_BWD, 32'h0);
    rd_chk("net_clr", `LRS_REG_NET, 32'h0);
    end_sim();
  end
endmodule

// ==== include/lrs_lut_if.sv ====
`timescale 1ns/1ps
// Link between the sequencer and its transition table
interface lrs_lut_if;
  logic wr_en;
  logic [3:0] wr_addr;
  lrs_pkg::lrs_move_t wr_data;
  logic [3:0] rd_addr;
  lrs_pkg::lrs_move_t rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface

// ==== include/lrs_map.svh ====
`ifndef LRS_MAP_SVH
`define LRS_MAP_SVH

// ==========================================================
// Timing
`define LRS_CLK_MHZ 40
`define LRS_KICK_NS 250
`define LRS_KICK_CYC ((`LRS_KICK_NS * `LRS_CLK_MHZ + 999) / 1000)
`define LRS_TMO_NS 39000
`define LRS_TMO_CYC ((`LRS_TMO_NS * `LRS_CLK_MHZ) / 1000)
`define LRS_OSC_TARGET 22
`define LRS_DAMP_CODE 16'h0002

// ==========================================================
// Register byte offsets
`define LRS_REG_CTRL 8'h00
`define LRS_REG_KICK 8'h04
`define LRS_REG_TARGET 8'h08
`define LRS_REG_TMO 8'h0c
`define LRS_REG_STATUS 8'h10
`define LRS_REG_FWD 8'h14
`define LRS_REG_BWD 8'h18
`define LRS_REG_NET 8'h1c
`define LRS_REG_CAP1 8'h20
`define LRS_REG_CAP2 8'h24

// ==========================================================
// Field positions
`define LRS_CTRL_EN 0
`define LRS_CTRL_CLR 1
`define LRS_ST_POS_LO 0
`define LRS_ST_POS_HI 1
`define LRS_ST_PREV_LO 2
`define LRS_ST_PREV_HI 3
`define LRS_ST_ERR 4
`define LRS_ST_BUSY 5
`define LRS_ST_READY 6

// ==========================================================
// Bus answers and table size
`define LRS_RESP_OKAY 2'b00
`define LRS_RESP_SLVERR 2'b10
`define LRS_LUT_LAST 4'hf

`endif

// ==== include/lrs_pkg.sv ====
package lrs_pkg;

  // One-hot sequencer states
  typedef enum logic [6:0] {
    ST_INIT = 7'h01,
    ST_IDLE = 7'h02,
    ST_KICK = 7'h04,
    ST_COUNT = 7'h08,
    ST_LOOK = 7'h10,
    ST_UPD = 7'h20,
    ST_SPARE = 7'h40
  } lrs_state_t;

  // Movement code held in the transition table
  typedef enum logic [1:0] {
    MV_NONE = 2'b00,
    MV_FWD = 2'b01,
    MV_BWD = 2'b10,
    MV_DIAG = 2'b11
  } lrs_move_t;

endpackage

// ==== rtl/lrs_lut_mem.sv ====
`timescale 1ns/1ps
// Sixteen-entry transition table, registered read
module lrs_lut_mem (
  input wire logic aclk, // System clock
  lrs_lut_if.mem lut // Table port
);
  lrs_pkg::lrs_move_t mem_r [16];

  // Write during init; contents have no reset, loader fills them
  always_ff @(posedge aclk) begin
    if (lut.wr_en) begin
      mem_r[lut.wr_addr] <= lut.wr_data;
    end
  end

  // Read data always comes from a flop
  always_ff @(posedge aclk) begin
    lut.rd_data <= mem_r[lut.rd_addr];
  end
endmodule

// ==== rtl/lrs_sequencer.sv ====
`timescale 1ns/1ps
`include "lrs_map.svh"
module lrs_sequencer (
  input wire logic aclk, // 40 MHz clock
  input wire logic aresetn, // Sync reset, low active
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic sample_tick, // Periodic wake pulse
  input wire logic [1:0] osc_sense_line, // Comparator outputs
  output logic [1:0] osc_kick_line // Kick pulses, low active
);

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Next position going forward around the disc
  function automatic logic [1:0] fwd_next(input logic [1:0] p);
    case (p)
      2'b00: return 2'b01;
      2'b01: return 2'b11;
      2'b11: return 2'b10;
      default: return 2'b00;
    endcase
  endfunction

  // Table entry for index {previous, current}
  function automatic lrs_pkg::lrs_move_t lut_entry(input logic [3:0] ix);
    if (ix[1:0] == fwd_next(ix[3:2])) begin
      return lrs_pkg::MV_FWD;
    end else if (ix[3:2] == fwd_next(ix[1:0])) begin
      return lrs_pkg::MV_BWD;
    end else if ((ix[3:2] ^ ix[1:0]) == 2'b11) begin
      return lrs_pkg::MV_DIAG;
    end
    return lrs_pkg::MV_NONE;
  endfunction

  // ==========================================================
  // Declarations
  lrs_pkg::lrs_state_t st_r;
  lrs_lut_if lut ();
  logic [3:0] init_idx_r;
  logic sel_r;
  logic [7:0] kick_cnt_r;
  logic [15:0] tmr_r;
  logic [7:0] osc_cnt_r;
  logic [1:0] sense_q_r;
  logic rise;
  logic hit_target;
  logic hit_tmo;
  logic meas_done;
  logic [1:0] pos_r;
  logic [1:0] prev_r;
  logic [15:0] cap_r [2];
  logic [31:0] fwd_r;
  logic [31:0] bwd_r;
  logic [31:0] net_r;
  logic err_r;
  logic en_r;
  logic clr_r;
  logic [7:0] kick_len_r;
  logic [7:0] target_r;
  logic [15:0] tmo_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  // ==========================================================
  // Transition table
  lrs_lut_mem u_lut (
    .aclk (aclk),
    .lut (lut.mem)
  );

  // Loader writes during init; reads always track the positions
  assign lut.wr_en = (st_r == lrs_pkg::ST_INIT);
  assign lut.wr_addr = init_idx_r;
  assign lut.wr_data = lut_entry(init_idx_r);
  assign lut.rd_addr = {prev_r, pos_r};

  // ==========================================================
  // Measurement conditions
  assign rise = osc_sense_line[sel_r] & ~sense_q_r[sel_r];
  assign hit_target = rise && (osc_cnt_r + 8'h01 == target_r);
  assign hit_tmo = (tmr_r >= tmo_r);
  assign meas_done = (st_r == lrs_pkg::ST_COUNT) && (hit_target || hit_tmo);

  // Sensor inputs are synchronous, one flop is only for edge finding
  generate
    for (genvar g = 0; g < 2; g++) begin : g_sense
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sense_q_r[g] <= 1'b0;
        end else begin
          sense_q_r[g] <= osc_sense_line[g];
        end
      end

      // Each kick line is idle high and pulses low only while selected
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          osc_kick_line[g] <= 1'b1;
        end else begin
          osc_kick_line[g] <= !((st_r == lrs_pkg::ST_KICK) &&
                                (sel_r == g[0]));
        end
      end
    end
  endgenerate

  // ==========================================================
  // Sequencer state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= lrs_pkg::ST_INIT;
    end else begin
      case (st_r)
        lrs_pkg::ST_INIT: begin
          if (init_idx_r == `LRS_LUT_LAST) begin
            st_r <= lrs_pkg::ST_IDLE;
          end
        end
        lrs_pkg::ST_IDLE: begin
          if (sample_tick && en_r) begin
            st_r <= lrs_pkg::ST_KICK;
          end
        end
        lrs_pkg::ST_KICK: begin
          if (kick_cnt_r + 8'h01 >= kick_len_r) begin
            st_r <= lrs_pkg::ST_COUNT;
          end
        end
        lrs_pkg::ST_COUNT: begin
          if (meas_done) begin
            st_r <= sel_r ? lrs_pkg::ST_LOOK : lrs_pkg::ST_KICK;
          end
        end
        lrs_pkg::ST_LOOK: begin
          st_r <= lrs_pkg::ST_UPD;
        end
        lrs_pkg::ST_UPD: begin
          st_r <= lrs_pkg::ST_IDLE;
        end
        default: begin
          st_r <= lrs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Table loader index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_idx_r <= 4'h0;
    end else if (st_r == lrs_pkg::ST_INIT) begin
      init_idx_r <= init_idx_r + 4'h1;
    end
  end

  // Sensor select: a wake always starts with the first sensor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= 1'b0;
    end else if (st_r == lrs_pkg::ST_IDLE) begin
      sel_r <= 1'b0;
    end else if (meas_done) begin
      sel_r <= 1'b1;
    end
  end

  // Kick length, interval timer and oscillation count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kick_cnt_r <= 8'h00;
      tmr_r <= 16'h0000;
      osc_cnt_r <= 8'h00;
    end else if (st_r == lrs_pkg::ST_KICK) begin
      kick_cnt_r <= kick_cnt_r + 8'h01;
      tmr_r <= tmr_r + 16'h0001;
      osc_cnt_r <= 8'h00;
    end else if (st_r == lrs_pkg::ST_COUNT) begin
      // Rewind for the second sensor, else its kick and timeout run short
      kick_cnt_r <= 8'h00;
      tmr_r <= meas_done ? 16'h0000 : tmr_r + 16'h0001;
      if (rise) begin
        osc_cnt_r <= osc_cnt_r + 8'h01;
      end
    end else begin
      kick_cnt_r <= 8'h00;
      tmr_r <= 16'h0000;
      osc_cnt_r <= 8'h00;
    end
  end

  // Capture and classify; target reached wins over a timeout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_r[0] <= 16'h0000;
      cap_r[1] <= 16'h0000;
      pos_r <= 2'b00;
    end else if (meas_done) begin
      if (hit_target) begin
        cap_r[sel_r] <= tmr_r;
        pos_r[~sel_r] <= 1'b0;
      end else begin
        cap_r[sel_r] <= `LRS_DAMP_CODE;
        pos_r[~sel_r] <= 1'b1;
      end
    end
  end

  // Position update and counters; a clear request beats an update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 2'b00;
      fwd_r <= 32'h0000_0000;
      bwd_r <= 32'h0000_0000;
    end else begin
      // Position is stored even when a clear wins over the count
      if (st_r == lrs_pkg::ST_UPD) begin
        prev_r <= pos_r;
      end
      if (clr_r) begin
        fwd_r <= 32'h0000_0000;
        bwd_r <= 32'h0000_0000;
      end else if (st_r == lrs_pkg::ST_UPD) begin
        case (lut.rd_data)
          lrs_pkg::MV_FWD: fwd_r <= fwd_r + 32'h0000_0001;
          lrs_pkg::MV_BWD: bwd_r <= bwd_r + 32'h0000_0001;
          default: begin
          end
        endcase
      end
    end
  end

  // Net count follows one cycle behind the two counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_r <= 32'h0000_0000;
    end else begin
      net_r <= fwd_r - bwd_r;
    end
  end

  // Undersampling flag: set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_r <= 1'b0;
    end else if (st_r == lrs_pkg::ST_UPD &&
                 lut.rd_data == lrs_pkg::MV_DIAG) begin
      err_r <= 1'b1;
    end else if (wr_fire && wr_ok && hit(aw_addr_r, `LRS_REG_STATUS) &&
                 w_strb_r[0] && w_data_r[`LRS_ST_ERR]) begin
      err_r <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= 1'b0;
      clr_r <= 1'b0;
      kick_len_r <= 8'(`LRS_KICK_CYC);
      target_r <= 8'(`LRS_OSC_TARGET);
      tmo_r <= 16'(`LRS_TMO_CYC);
    end else begin
      clr_r <= 1'b0;
      if (wr_fire && hit(aw_addr_r, `LRS_REG_CTRL) && w_strb_r[0]) begin
        en_r <= w_data_r[`LRS_CTRL_EN];
        clr_r <= w_data_r[`LRS_CTRL_CLR];
      end
      if (wr_fire && hit(aw_addr_r, `LRS_REG_KICK)) begin
        kick_len_r <= 8'(merge({24'h0, kick_len_r}, w_data_r,
                               w_strb_r));
      end
      if (wr_fire && hit(aw_addr_r, `LRS_REG_TARGET)) begin
        target_r <= 8'(merge({24'h0, target_r}, w_data_r,
                             w_strb_r));
      end
      if (wr_fire && hit(aw_addr_r, `LRS_REG_TMO)) begin
        tmo_r <= 16'(merge({16'h0, tmo_r}, w_data_r, w_strb_r));
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write side; one write in flight, channels in any order
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_ok = hit(aw_addr_r, `LRS_REG_CTRL) ||
                 hit(aw_addr_r, `LRS_REG_KICK) ||
                 hit(aw_addr_r, `LRS_REG_TARGET) ||
                 hit(aw_addr_r, `LRS_REG_TMO) ||
                 hit(aw_addr_r, `LRS_REG_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
    end else if (!aw_got_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
    end else if (!w_got_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Read-only registers take writes silently; unmapped ones get SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LRS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ok || rd_hit_w()) ? `LRS_RESP_OKAY
                                          : `LRS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic rd_hit_w();
    return hit(aw_addr_r, `LRS_REG_FWD) || hit(aw_addr_r, `LRS_REG_BWD) ||
           hit(aw_addr_r, `LRS_REG_NET) || hit(aw_addr_r, `LRS_REG_CAP1) ||
           hit(aw_addr_r, `LRS_REG_CAP2);
  endfunction

  // ==========================================================
  // AXI4-Lite read side; previous position is visible only as status
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, `LRS_REG_CTRL)) begin
      rd_val[`LRS_CTRL_EN] = en_r;
    end else if (hit(s_axi_araddr, `LRS_REG_KICK)) begin
      rd_val[7:0] = kick_len_r;
    end else if (hit(s_axi_araddr, `LRS_REG_TARGET)) begin
      rd_val[7:0] = target_r;
    end else if (hit(s_axi_araddr, `LRS_REG_TMO)) begin
      rd_val[15:0] = tmo_r;
    end else if (hit(s_axi_araddr, `LRS_REG_STATUS)) begin
      rd_val[`LRS_ST_POS_HI:`LRS_ST_POS_LO] = pos_r;
      rd_val[`LRS_ST_PREV_HI:`LRS_ST_PREV_LO] = prev_r;
      rd_val[`LRS_ST_ERR] = err_r;
      rd_val[`LRS_ST_BUSY] = !(st_r == lrs_pkg::ST_IDLE ||
                               st_r == lrs_pkg::ST_INIT);
      rd_val[`LRS_ST_READY] = (st_r != lrs_pkg::ST_INIT);
    end else if (hit(s_axi_araddr, `LRS_REG_FWD)) begin
      rd_val = fwd_r;
    end else if (hit(s_axi_araddr, `LRS_REG_BWD)) begin
      rd_val = bwd_r;
    end else if (hit(s_axi_araddr, `LRS_REG_NET)) begin
      rd_val = net_r;
    end else if (hit(s_axi_araddr, `LRS_REG_CAP1)) begin
      rd_val[15:0] = cap_r[0];
    end else if (hit(s_axi_araddr, `LRS_REG_CAP2)) begin
      rd_val[15:0] = cap_r[1];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // One read in flight; data are captured on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LRS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `LRS_RESP_OKAY : `LRS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule
